/* design/els_query_resp.sv */
// extended link service responder for speed report and exchange queries
`timescale 1ns/1ps
module els_query_resp
   import els_pkg::*;
#(
   parameter int         XCHG_DEPTH  = 8,
   // reject encodings are set by the fabric integration
   parameter logic [7:0] RJT_CMD     = 8'h01,
   parameter logic [7:0] RSN_UNSUP   = 8'h01,
   parameter logic [7:0] RSN_UNABLE  = 8'h02,
   parameter logic [7:0] EXP_NONE    = 8'h00,
   parameter logic [7:0] EXP_BAD_ORIG = 8'h01,
   parameter logic [7:0] EXP_BAD_XID = 8'h02
)(
   input  wire logic                          sys_clk,
   input  wire logic                          reset_n,
   input  wire logic                          speed_rpt_en,
   input  wire els_speed_s                    speed,
   input  wire logic                          req_valid,
   input  wire els_req_s                      req,
   output logic                               req_ready,
   output logic                               rsp_valid,
   input  wire logic                          rsp_ready,
   output els_rsp_s                           rsp,
   input  wire logic                          xchg_wr_en,
   input  wire logic [$clog2(XCHG_DEPTH)-1:0] xchg_wr_idx,
   input  wire els_xchg_s                     xchg_wr_entry,
   output logic [1:0]                         last_rjt
);
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EVAL,
      ST_REPLY
   } els_state_e;

   els_state_e state_q, state_d;
   els_req_s   req_q, req_d;
   els_rsp_s   rsp_q, rsp_d;
   logic       req_ready_q, req_ready_d;
   logic       rsp_valid_q, rsp_valid_d;
   logic [1:0] last_rjt_q, last_rjt_d;

   logic [31:0] spd_w0;
   logic [31:0] spd_w1;
   logic        x_hit;
   logic        x_ok;
   els_xchg_s   x_ent;
   logic [7:0]  req_cmd;

   assign req_cmd = req_q.word0[31:24];

   initial begin
      if (XCHG_DEPTH < 2) $error("els_query_resp: XCHG_DEPTH must be at least 2");
   end

   els_speed_fmt u_speed (
      .spd   (speed),
      .word0 (spd_w0),
      .word1 (spd_w1)
   );

   els_xchg_table #(.DEPTH(XCHG_DEPTH)) u_table (
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .wr_en      (xchg_wr_en),
      .wr_idx     (xchg_wr_idx),
      .wr_entry   (xchg_wr_entry),
      .q_orig_id  (req_q.word1[23:0]),
      .q_ox_id    (req_q.word2[31:16]),
      .q_rx_id    (req_q.word2[15:0]),
      .hit        (x_hit),
      .consistent (x_ok),
      .entry      (x_ent)
   );

   function automatic els_rsp_s make_rjt(input els_rjt_e kind, input logic [7:0] rsn, input logic [7:0] exp);
      els_rsp_s r;
      r = '0;
      r.rjt_kind = kind;
      r.nwords = REJECT_WORDS;
      r.word[0] = {RJT_CMD, 24'h000000};
      r.word[1] = {8'h00, rsn, exp, 8'h00};
      return r;
   endfunction

   always_comb begin
      state_d     = state_q;
      req_d       = req_q;
      rsp_d       = rsp_q;
      req_ready_d = req_ready_q;
      rsp_valid_d = rsp_valid_q;
      last_rjt_d  = last_rjt_q;
      case (state_q)
         ST_IDLE: begin
            if (req_valid) begin
               req_d       = req;
               req_ready_d = 1'b0;
               state_d     = ST_EVAL;
            end
         end
         ST_EVAL: begin
            rsp_d = '0;
            if (req_cmd == CMD_SPEED_RPT && speed_rpt_en) begin
               rsp_d.accept  = 1'b1;
               rsp_d.nwords  = SPEED_RPT_WORDS;
               rsp_d.word[0] = spd_w0;
               rsp_d.word[1] = spd_w1;
            end else if (req_cmd == CMD_XCHG_QRY) begin
               if (!x_hit || !x_ok) begin
                  rsp_d = make_rjt(RJT_BAD_XID_COMBO, RSN_UNABLE, EXP_BAD_XID);
               end else if (req_q.requester_id != x_ent.orig_id && req_q.requester_id != x_ent.resp_id) begin
                  rsp_d = make_rjt(RJT_BAD_ORIGINATOR, RSN_UNABLE, EXP_BAD_ORIG);
               end else begin
                  rsp_d.accept  = 1'b1;
                  rsp_d.nwords  = XCHG_ACC_WORDS;
                  rsp_d.word[0] = {CMD_ACCEPT, 24'h000000};
                  rsp_d.word[1] = {x_ent.ox_id, x_ent.rx_id};
                  rsp_d.word[2] = {8'h00, x_ent.orig_id};
                  rsp_d.word[3] = {8'h00, x_ent.resp_id};
                  rsp_d.word[4] = x_ent.fc4value;
                  rsp_d.word[5] = x_ent.estat;
                  rsp_d.word[5][ESTAT_DONE_BIT] = x_ent.complete;
                  rsp_d.word[5][ESTAT_SI_BIT] = x_ent.resp_holds_si;
               end
            end else begin
               // unknown commands share the disabled-service answer
               rsp_d = make_rjt(RJT_CMD_UNSUPPORTED, RSN_UNSUP, EXP_NONE);
            end
            rsp_d.rel_off   = 1'b0;
            rsp_d.hdr_param = req_q.hdr_param;
            last_rjt_d      = rsp_d.rjt_kind;
            rsp_valid_d     = 1'b1;
            state_d         = ST_REPLY;
         end
         ST_REPLY: begin
            if (rsp_ready) begin
               rsp_valid_d = 1'b0;
               req_ready_d = 1'b1;
               state_d     = ST_IDLE;
            end
         end
         default: begin
            state_d     = ST_IDLE;
            req_ready_d = 1'b1;
            rsp_valid_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q     <= ST_IDLE;
         req_q       <= '0;
         rsp_q       <= '0;
         req_ready_q <= 1'b1;
         rsp_valid_q <= 1'b0;
         last_rjt_q  <= 2'h0;
      end else begin
         state_q     <= state_d;
         req_q       <= req_d;
         rsp_q       <= rsp_d;
         req_ready_q <= req_ready_d;
         rsp_valid_q <= rsp_valid_d;
         last_rjt_q  <= last_rjt_d;
      end
   end

   assign req_ready = req_ready_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp       = rsp_q;
   assign last_rjt  = last_rjt_q;

   // checks on the reply formation
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence s_eval_speed;
      state_q == ST_EVAL && req_cmd == CMD_SPEED_RPT;
   endsequence

   sequence s_eval_xchg;
      state_q == ST_EVAL && req_cmd == CMD_XCHG_QRY;
   endsequence

   sequence s_take;
      state_q == ST_IDLE && req_valid;
   endsequence

   property p_unsupported;
      s_eval_speed ##0 !speed_rpt_en |=> rsp_valid && !rsp.accept && rsp.rjt_kind == RJT_CMD_UNSUPPORTED;
   endproperty
   a_unsupported: assert property (p_unsupported) else $error("disabled speed report not rejected");

   property p_speed_w0;
      s_eval_speed ##0 speed_rpt_en |=> rsp.accept && rsp.word[0][31:24] == CMD_ACCEPT
         && rsp.word[0][15:0] == SPEED_ENTRIES && rsp.word[0][23:17] == 7'h00;
   endproperty
   a_speed_w0: assert property (p_speed_w0) else $error("speed accept word 0 malformed");

   property p_phy_flag;
      s_eval_speed ##0 speed_rpt_en |=> rsp.word[0][FLAG_PHY_BIT] == $past(speed.phy_eth);
   endproperty
   a_phy_flag: assert property (p_phy_flag) else $error("phy type flag wrong");

   property p_fixed_speed;
      s_eval_speed ##0 (speed_rpt_en && speed.cfg_fixed) |=> rsp.word[1][CAP_FIXED_BIT]
         && (rsp.word[1][15:6] & $past(speed.cfg_speed)) != 10'h000;
   endproperty
   a_fixed_speed: assert property (p_fixed_speed) else $error("configured speed not reported");

   property p_inactive;
      s_eval_speed ##0 (speed_rpt_en && speed.cfg_fixed && !speed.port_active) |=> rsp.word[1][OPER_NOT_EST_BIT];
   endproperty
   a_inactive: assert property (p_inactive) else $error("inactive fixed port lacks bit 0");

   property p_bad_combo;
      s_eval_xchg ##0 (!x_hit || !x_ok) |=> !rsp.accept && rsp.rjt_kind == RJT_BAD_XID_COMBO;
   endproperty
   a_bad_combo: assert property (p_bad_combo) else $error("inconsistent ids not rejected");

   property p_bad_orig;
      s_eval_xchg ##0 (x_hit && x_ok && req_q.requester_id != x_ent.orig_id
         && req_q.requester_id != x_ent.resp_id) |=> rsp.rjt_kind == RJT_BAD_ORIGINATOR;
   endproperty
   a_bad_orig: assert property (p_bad_orig) else $error("foreign requester not rejected");

   property p_xchg_acc;
      s_eval_xchg ##0 (x_hit && x_ok && (req_q.requester_id == x_ent.orig_id || req_q.requester_id == x_ent.resp_id))
         |=> rsp.accept && rsp.nwords == XCHG_ACC_WORDS && rsp.word[0] == {CMD_ACCEPT, 24'h000000}
         && rsp.word[2] == {8'h00, $past(x_ent.orig_id)} && rsp.word[3] == {8'h00, $past(x_ent.resp_id)}
         && rsp.word[5][ESTAT_DONE_BIT] == $past(x_ent.complete)
         && rsp.word[5][ESTAT_SI_BIT] == $past(x_ent.resp_holds_si);
   endproperty
   a_xchg_acc: assert property (p_xchg_acc) else $error("exchange accept malformed");

   property p_rel_off;
      rsp_valid |-> !rsp.rel_off;
   endproperty
   a_rel_off: assert property (p_rel_off) else $error("relative offset bit set in reply");

   property p_timing;
      s_take |=> state_q == ST_EVAL ##1 rsp_valid;
   endproperty
   a_timing: assert property (p_timing) else $error("reply not produced two cycles after request");
endmodule

/* pkg/els_pkg.sv */
// shared constants and carriers for the link service query responder
package els_pkg;
   localparam logic [7:0]  CMD_SPEED_RPT   = 8'h7D;
   localparam logic [7:0]  CMD_XCHG_QRY    = 8'h13;
   localparam logic [7:0]  CMD_ACCEPT      = 8'h02;
   localparam logic [15:0] SPEED_ENTRIES   = 16'h0001;
   localparam logic [15:0] XID_UNASSIGNED  = 16'hFFFF;
   localparam logic [2:0]  SPEED_RPT_WORDS = 3'h2;
   localparam logic [2:0]  XCHG_ACC_WORDS  = 3'h6;
   localparam logic [2:0]  REJECT_WORDS    = 3'h2;
   // field positions inside reply words
   localparam int          FLAG_PHY_BIT    = 16;
   localparam int          CAP_FIXED_BIT   = 17;
   localparam int          CAP_UNKNOWN_BIT = 16;
   localparam int          OPER_UNKNOWN_BIT = 1;
   localparam int          OPER_NOT_EST_BIT = 0;
   localparam int          ESTAT_DONE_BIT  = 29;
   localparam int          ESTAT_SI_BIT    = 30;
   localparam int          SPEED_BITS      = 10;
   // ethernet phy defines only the upper seven speed positions
   localparam logic [9:0]  ETH_SPEED_MASK  = 10'h3F8;
   localparam logic [9:0]  FC_SPEED_MASK   = 10'h3FF;

   typedef enum logic [1:0] {
      RJT_NONE,
      RJT_CMD_UNSUPPORTED,
      RJT_BAD_ORIGINATOR,
      RJT_BAD_XID_COMBO
   } els_rjt_e;

   typedef struct packed {
      logic [31:0] word0;
      logic [31:0] word1;
      logic [31:0] word2;
      logic [23:0] requester_id;
      logic        rel_off;
      logic [31:0] hdr_param;
   } els_req_s;

   typedef struct packed {
      logic        accept;
      els_rjt_e    rjt_kind;
      logic [2:0]  nwords;
      logic        rel_off;
      logic [31:0] hdr_param;
      logic [5:0][31:0] word;
   } els_rsp_s;

   typedef struct packed {
      logic        phy_eth;
      logic [9:0]  cap;
      logic        cap_unknown;
      logic        cfg_fixed;
      logic [9:0]  cfg_speed;
      logic [9:0]  oper;
      logic        oper_unknown;
      logic        port_active;
      logic        diag_ctx;
   } els_speed_s;

   typedef struct packed {
      logic        valid;
      logic        local_is_orig;
      logic [15:0] ox_id;
      logic [15:0] rx_id;
      logic [23:0] orig_id;
      logic [23:0] resp_id;
      logic        complete;
      logic        resp_holds_si;
      logic [31:0] fc4value;
      logic [31:0] estat;
   } els_xchg_s;
endpackage

/* design/els_speed_fmt.sv */
// builds the two words of the speed report accept reply
`timescale 1ns/1ps
module els_speed_fmt
   import els_pkg::*;
(
   input  wire els_speed_s  spd,
   output logic [31:0]      word0,
   output logic [31:0]      word1
);
   logic [9:0] mask;
   logic [9:0] oper_bits;

   always_comb begin
      mask      = spd.phy_eth ? ETH_SPEED_MASK : FC_SPEED_MASK;
      oper_bits = (spd.oper | (spd.cfg_fixed ? spd.cfg_speed : '0)) & mask;
      word0 = '0;
      word0[31:24] = CMD_ACCEPT;
      word0[FLAG_PHY_BIT] = spd.phy_eth;
      word0[15:0] = SPEED_ENTRIES;
      word1 = '0;
      word1[31:22] = spd.cap & mask;
      word1[CAP_FIXED_BIT] = spd.cfg_fixed;
      word1[CAP_UNKNOWN_BIT] = spd.cap_unknown;
      word1[15:6] = oper_bits;
      word1[OPER_UNKNOWN_BIT] = spd.oper_unknown;
      // not-established is set for an inactive port that is fixed-speed or in the diagnostic descriptor context
      word1[OPER_NOT_EST_BIT] = !spd.port_active && (spd.cfg_fixed || spd.diag_ctx);
   end
endmodule

/* design/els_xchg_table.sv */
// local exchange state table with query lookup
`timescale 1ns/1ps
module els_xchg_table
   import els_pkg::*;
#(
   parameter int DEPTH = 8
)(
   input  wire logic                     sys_clk,
   input  wire logic                     reset_n,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
   input  wire els_xchg_s                wr_entry,
   input  wire logic [23:0]              q_orig_id,
   input  wire logic [15:0]              q_ox_id,
   input  wire logic [15:0]              q_rx_id,
   output logic                          hit,
   output logic                          consistent,
   output els_xchg_s                     entry
);
   els_xchg_s tbl_q [DEPTH];

   initial begin
      if (DEPTH < 2) $error("els_xchg_table: DEPTH must be at least 2");
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < DEPTH; i++) tbl_q[i] <= '0;
      end else if (wr_en) begin
         tbl_q[wr_idx] <= wr_entry;
      end
   end

   // lowest-index matching entry wins; key depends on our role in the exchange
   always_comb begin
      logic key;
      logic ok;
      key = 1'b0;
      ok  = 1'b0;
      hit = 1'b0;
      consistent = 1'b0;
      entry = '0;
      for (int i = DEPTH - 1; i >= 0; i--) begin
         if (tbl_q[i].local_is_orig) begin
            key = tbl_q[i].ox_id == q_ox_id;
            ok  = tbl_q[i].rx_id == q_rx_id && tbl_q[i].orig_id == q_orig_id;
         end else if (q_rx_id == XID_UNASSIGNED) begin
            key = tbl_q[i].orig_id == q_orig_id && tbl_q[i].ox_id == q_ox_id;
            ok  = 1'b1;
         end else begin
            key = tbl_q[i].rx_id == q_rx_id;
            ok  = tbl_q[i].ox_id == q_ox_id && tbl_q[i].orig_id == q_orig_id;
         end
         if (tbl_q[i].valid && key) begin
            hit = 1'b1;
            consistent = ok;
            entry = tbl_q[i];
         end
      end
   end
endmodule

/* verif/els_requester.sv */
// remote port model that issues link service requests and takes the replies
`timescale 1ns/1ps
module els_requester
   import els_pkg::*;
(
   input  wire logic     sys_clk,
   input  wire logic     reset_n,
   output logic          req_valid,
   output els_req_s      req,
   input  wire logic     req_ready,
   input  wire logic     rsp_valid,
   output logic          rsp_ready,
   input  wire els_rsp_s rsp
);
   initial begin
      req_valid = 1'b0;
      req       = '0;
      rsp_ready = 1'b0;
   end

   // one request outstanding; stall delays acceptance of the reply
   task automatic send(input els_req_s r, input int stall, output els_rsp_s first,
                       output els_rsp_s got, output int lat);
      int n;
      n = 0;
      @(negedge sys_clk);
      while (req_ready !== 1'b1 && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      req       <= r;
      req_valid <= 1'b1;
      @(negedge sys_clk);
      req_valid <= 1'b0;
      // a released payload must not look valid
      req       <= ~r;
      lat = 1;
      while (rsp_valid !== 1'b1 && lat < 50) begin
         @(negedge sys_clk);
         lat++;
      end
      first = rsp;
      repeat (stall) @(negedge sys_clk);
      got = rsp;
      rsp_ready <= 1'b1;
      @(negedge sys_clk);
      rsp_ready <= 1'b0;
   endtask
endmodule

/* verif/testbench.sv */
// self-checking bench for the link service query responder
`timescale 1ns/1ps
module testbench
   import els_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        speed_rpt_en = 1'b1;
   els_speed_s  speed = '0;
   logic        req_valid;
   els_req_s    req;
   logic        req_ready;
   logic        rsp_valid;
   logic        rsp_ready;
   els_rsp_s    rsp;
   logic        xchg_wr_en = 1'b0;
   logic [2:0]  xchg_wr_idx = 3'h0;
   els_xchg_s   xchg_wr_entry = '0;
   logic [1:0]  last_rjt;
   els_xchg_s   ent [2];
   int          fails = 0;
   int          total_checks = 0;

   always #5 sys_clk = ~sys_clk;

   els_query_resp #(.XCHG_DEPTH(8)) u_els_query_resp (
      .sys_clk(sys_clk), .reset_n(reset_n), .speed_rpt_en(speed_rpt_en), .speed(speed),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_ready(rsp_ready), .rsp(rsp), .xchg_wr_en(xchg_wr_en), .xchg_wr_idx(xchg_wr_idx),
      .xchg_wr_entry(xchg_wr_entry), .last_rjt(last_rjt));

   els_requester u_els_requester (
      .sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, seen);
         fails++;
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   function automatic logic [5:0][31:0] rj_w(input logic [7:0] rsn, input logic [7:0] expl);
      rj_w = '0;
      rj_w[0] = {8'h01, 24'h000000};
      rj_w[1] = {8'h00, rsn, expl, 8'h00};
   endfunction

   // sends one request, checks reply latency and that the reply stood still
   task automatic run(input els_req_s r, input int stall, output els_rsp_s got);
      els_rsp_s first;
      int       lat;
      u_els_requester.send(r, stall, first, got, lat);
      check("latency", lat, 2);
      check("reply held", {31'h0, first === got}, 32'h1);
      check("hdr_param", got.hdr_param, r.hdr_param);
      check("req_ready back", req_ready, 1'b1);
      check("rsp_valid dropped", rsp_valid, 1'b0);
   endtask

   task automatic exp_rsp(input els_rsp_s got, input logic acc, input els_rjt_e k,
                          input logic [2:0] n, input logic [5:0][31:0] w);
      check("accept", got.accept, acc);
      check("rjt_kind", got.rjt_kind, k);
      check("last_rjt", last_rjt, k);
      check("nwords", got.nwords, n);
      check("rel_off", got.rel_off, 1'b0);
      for (int i = 0; i < n; i++)
         check("word", got.word[i], w[i]);
   endtask

   task automatic t_unsup;
      els_rsp_s got;
      els_req_s r;
      r = '0;
      speed_rpt_en = 1'b0;
      r.word0 = {CMD_SPEED_RPT, 24'h000000};
      r.hdr_param = 32'h3C3C_0001;
      run(r, 0, got);
      exp_rsp(got, 1'b0, RJT_CMD_UNSUPPORTED, REJECT_WORDS, rj_w(8'h01, 8'h00));
      speed_rpt_en = 1'b1;
      // a command the block does not serve shares the unsupported answer
      r.word0 = {8'h52, 24'h000000};
      r.hdr_param = 32'h0000_5200;
      run(r, 2, got);
      exp_rsp(got, 1'b0, RJT_CMD_UNSUPPORTED, REJECT_WORDS, rj_w(8'h01, 8'h00));
   endtask

   task automatic t_speed(input logic phy, input logic fixed, input logic active, input logic diag);
      els_rsp_s         got;
      els_req_s         r;
      logic [9:0]       m;
      logic [5:0][31:0] w;
      m = phy ? ETH_SPEED_MASK : FC_SPEED_MASK;
      speed.phy_eth      = phy;
      speed.cap          = 10'h3C5;
      speed.cap_unknown  = !fixed;
      speed.cfg_fixed    = fixed;
      speed.cfg_speed    = 10'h020;
      speed.oper         = fixed ? 10'h000 : 10'h100;
      speed.oper_unknown = diag;
      speed.port_active  = active;
      speed.diag_ctx     = diag;
      r = '0;
      r.word0 = {CMD_SPEED_RPT, 24'h000000};
      r.hdr_param = 32'hA5A5_0001;
      w = '0;
      w[0] = {CMD_ACCEPT, 7'h00, phy, 16'h0001};
      w[1] = {10'h3C5 & m, 4'h0, fixed, !fixed, ((fixed ? 10'h020 : 10'h000) | speed.oper) & m,
              4'h0, diag, !active && (fixed || diag)};
      run(r, phy ? 3 : 0, got);
      exp_rsp(got, 1'b1, RJT_NONE, SPEED_RPT_WORDS, w);
   endtask

   task automatic t_load(input logic [2:0] idx, input els_xchg_s e);
      @(negedge sys_clk);
      xchg_wr_en    = 1'b1;
      xchg_wr_idx   = idx;
      xchg_wr_entry = e;
      @(negedge sys_clk);
      xchg_wr_en    = 1'b0;
   endtask

   task automatic t_xchg(input logic [23:0] src, input logic [23:0] orig, input logic [15:0] ox,
                         input logic [15:0] rx, input els_rjt_e k, input int e);
      els_rsp_s         got;
      els_req_s         r;
      logic [5:0][31:0] w;
      r = '0;
      r.word0 = {CMD_XCHG_QRY, 24'h000000};
      r.word1 = {8'h00, orig};
      r.word2 = {ox, rx};
      r.requester_id = src;
      r.hdr_param = {8'h5C, orig};
      w = '0;
      w[0] = {CMD_ACCEPT, 24'h000000};
      w[1] = {ent[e].ox_id, ent[e].rx_id};
      w[2] = {8'h00, ent[e].orig_id};
      w[3] = {8'h00, ent[e].resp_id};
      w[4] = ent[e].fc4value;
      w[5] = ent[e].estat;
      w[5][29] = ent[e].complete;
      w[5][30] = ent[e].resp_holds_si;
      run(r, 1, got);
      if (k == RJT_NONE)
         exp_rsp(got, 1'b1, k, XCHG_ACC_WORDS, w);
      else
         exp_rsp(got, 1'b0, k, REJECT_WORDS, rj_w(8'h02, k == RJT_BAD_ORIGINATOR ? 8'h01 : 8'h02));
   endtask

   initial begin
      repeat (3000) @(posedge sys_clk);
      fails++;
      give_verdict();
   end

   initial begin
      ent[0] = '{1'b1, 1'b1, 16'h1234, 16'h5678, 24'h010203, 24'h0A0B0C, 1'b1, 1'b0,
                 32'hC0FF_EE01, 32'hFFFF_FFFF};
      ent[1] = '{1'b1, 1'b0, 16'h0042, 16'h0099, 24'h112233, 24'h445566, 1'b0, 1'b1,
                 32'h1234_5678, 32'h0000_0000};
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      reset_n = 1'b1;
      t_unsup();
      t_speed(1'b0, 1'b1, 1'b0, 1'b0);
      t_speed(1'b1, 1'b1, 1'b1, 1'b0);
      t_speed(1'b0, 1'b0, 1'b0, 1'b1);
      t_speed(1'b1, 1'b0, 1'b0, 1'b0);
      t_load(3'h0, ent[0]);
      t_load(3'h7, ent[1]);
      t_xchg(24'h0A0B0C, 24'h010203, 16'h1234, 16'h5678, RJT_NONE, 0);
      t_xchg(24'h112233, 24'h112233, 16'h0042, 16'h0099, RJT_NONE, 1);
      t_xchg(24'h112233, 24'h112233, 16'h0042, 16'hFFFF, RJT_NONE, 1);
      t_xchg(24'h777777, 24'h010203, 16'h1234, 16'h5678, RJT_BAD_ORIGINATOR, 0);
      t_xchg(24'h0A0B0C, 24'h010203, 16'h1234, 16'h5679, RJT_BAD_XID_COMBO, 0);
      t_xchg(24'h445566, 24'h112233, 16'h0043, 16'h0099, RJT_BAD_XID_COMBO, 1);
      give_verdict();
   end
endmodule
